//--- core/sws_sequencer.v
// Sleep/wake sequencer with alarm wake path and power button hold override
`timescale 1ns/1ps
`default_nettype none
`include "sws_map.vh"

// Contract
// - Sleep trigger write sequences system into state chosen by sleep type select.
// - Button held over four seconds forces off unconditionally.
// - Enabled wake event in any sleeping state returns system to working.
// - Wake only accepted once processor has stopped; then wake flag sets.
// - Wake from S1 resumes in driver; deeper states restart at reset vector.
// - Without lightest sleep support the wake flag may read zero.
// - Several sleep states; change them by waking, reprogramming, re-triggering.
// - Alarm wakes from S1 to S3; S4 wake only if deep support flag set.
// - Alarm sets alarm flag; enabled alarm raises wake unless battery low.
// - Alarm flag is set from the clock chip interrupt pin.
// - Alarm status and enable bits behave exactly as the alarm path demands.
// - Day byte holds 01-31 BCD or 01-1F binary; top two bits ignored.
// - Out-of-range day byte reverts alarm to plain time-of-day match.
// - Month byte 01-12 BCD or 01-0C binary; out-of-range disables month match.
// - Month alarm present implies day alarm present.
// - Century byte holds year hundreds: 19 BCD or 13 hex binary.
// - Extended bytes live in bank 0; zero location means feature absent.
// - Button hold override clears the power button flag.
module sws_sequencer #(
  parameter HOLD_CYC = `SWS_HOLD_CYC,
  parameter [0:0] S1_SUPPORT = 1'b1,
  parameter [0:0] DEEP_ALARM_WAKE_SUPPORT = 1'b0,
  parameter [7:0] DAY_MATCH_LOCATION = 8'h0d,
  parameter [7:0] MONTH_MATCH_LOCATION = 8'h0e,
  parameter [7:0] CENTENARY_POINTER = 8'h32
) (
  input wire sys_clk,
  input wire nrst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire power_button_pin,
  input wire alarm_irq_pin,
  input wire battery_low_pin,
  input wire cpu_halted_pin,
  input wire bcd_mode,
  output reg [2:0] power_state,
  output reg cpu_resume_in_driver,
  output reg cpu_reset_vector,
  output reg sleep_busy
);

  // Sequencer states:
  // WORK  - system running, trigger writes are honoured here only
  // ENTER - fixed settle time counted from entry; left once it has run out and the processor has stopped
  // SLEEP - low-power state held, waiting for an enabled wake event
  // WAKE  - fixed power-up time before handing back to software
  // OFF   - soft-off, left only by a fresh button press
  // The settle times are fixed counts; a platform with slower rails
  // must raise the sequence count in the map header.
  localparam ST_WORK = 3'h0;
  localparam ST_ENTER = 3'h1;
  localparam ST_SLEEP = 3'h2;
  localparam ST_WAKE = 3'h3;
  localparam ST_OFF = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] sleep_type_select_r;
  reg [2:0] cur_type_r;
  reg wake_flag_r;
  reg alarm_wake_flag_r;
  reg power_button_flag_r;
  reg override_flag_r;
  reg alarm_en_r;
  reg [7:0] day_alarm_r;
  reg [7:0] mon_alarm_r;
  reg [7:0] century_r;
  reg [7:0] cur_day_r;
  reg [7:0] cur_mon_r;
  reg [7:0] seq_cnt_r;
  reg [31:0] hold_cnt_r;
  reg [1:0] pb_sync_r;
  reg [1:0] irq_sync_r;
  reg [1:0] bat_sync_r;
  reg [1:0] halt_sync_r;
  reg pb_prev_r;
  reg irq_prev_r;

  wire pb_level = pb_sync_r[1];
  wire irq_level = irq_sync_r[1];
  wire bat_low = bat_sync_r[1];
  wire cpu_halted = halt_sync_r[1];
  wire pb_press = pb_level & ~pb_prev_r;
  wire irq_rise = irq_level & ~irq_prev_r;
  wire wr_ctrl = reg_wr & (reg_addr == `SWS_OFF_CTRL);
  wire wr_stat = reg_wr & (reg_addr == `SWS_OFF_STAT);
  wire trigger = wr_ctrl & reg_wdata[`SWS_CTRL_TRIG];
  wire [2:0] wr_type = reg_wdata[`SWS_CTRL_TYPE_LO+2:`SWS_CTRL_TYPE_LO];

  // Range checks; top two day bits are ignored by the check
  // day byte range
  // out of range matches any day
  // The BCD test also rejects non-decimal low digits such as 0x1a.
  wire [5:0] day_v = day_alarm_r[5:0];
  wire day_ok = bcd_mode ? (day_v >= 6'h01 && day_v <= 6'h31 && day_v[3:0] <= 4'h9) :
                (day_v >= 6'h01 && day_v <= 6'h1f);
  // month range check
  // Month uses all eight bits, unlike the day byte.
  wire mon_ok = bcd_mode ? (mon_alarm_r >= 8'h01 && mon_alarm_r <= 8'h12 &&
                mon_alarm_r[3:0] <= 4'h9) : (mon_alarm_r >= 8'h01 && mon_alarm_r <= 8'h0c);
  // Absent features never gate the match
  // zero location absent
  wire day_present = (DAY_MATCH_LOCATION != 8'h00);
  wire mon_present = (MONTH_MATCH_LOCATION != 8'h00) & day_present;
  // A don't-care or absent byte widens the match instead of blocking it,
  // so a badly programmed byte can never silence the alarm.
  wire day_hit = ~day_present | ~day_ok | (cur_day_r[5:0] == day_v);
  wire mon_hit = ~mon_present | ~mon_ok | (cur_mon_r == mon_alarm_r);

  // Alarm may wake S1..S3, S4 only with deep support
  // alarm sleep states
  wire alarm_state_ok = (cur_type_r >= `SWS_TYPE_S1 && cur_type_r <= `SWS_TYPE_S3) |
                        ((cur_type_r == `SWS_TYPE_S4) & DEEP_ALARM_WAKE_SUPPORT);
  // pin edge status
  // Only the rising edge counts, so a pin left high cannot wake twice.
  wire alarm_event = irq_rise & day_hit & mon_hit;
  // enable and battery
  // A low battery blocks the wake but still lets the flag record the alarm.
  wire alarm_wake = alarm_event & alarm_en_r & ~bat_low & alarm_state_ok;
  wire button_wake = pb_press;
  wire wake_event = alarm_wake | button_wake;
  wire hold_done = (hold_cnt_r >= HOLD_CYC);

  // Input synchronisers, two flops each
  // All four pins are asynchronous to the sequencer clock. Only the second
  // flop of each pair is read; the edge detectors reset to the idle low
  // level so no false edge follows reset.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pb_sync_r <= 2'h0;
      irq_sync_r <= 2'h0;
      bat_sync_r <= 2'h0;
      halt_sync_r <= 2'h0;
      pb_prev_r <= 1'b0;
      irq_prev_r <= 1'b0;
    end else begin
      pb_sync_r <= {pb_sync_r[0], power_button_pin};
      irq_sync_r <= {irq_sync_r[0], alarm_irq_pin};
      bat_sync_r <= {bat_sync_r[0], battery_low_pin};
      halt_sync_r <= {halt_sync_r[0], cpu_halted_pin};
      pb_prev_r <= pb_level;
      irq_prev_r <= irq_level;
    end
  end

  // Button hold counter; saturates so a long press fires once
  // The count is taken after the synchroniser, so the override comes a few
  // cycles past the nominal hold time; the margin is far below the length
  // of any human press.
  // hold time count
  always @(posedge sys_clk) begin
    if (!nrst)
      hold_cnt_r <= 32'h0;
    else if (!pb_level)
      hold_cnt_r <= 32'h0;
    else if (!hold_done)
      hold_cnt_r <= hold_cnt_r + 32'h1;
  end

  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_WORK: begin
        if (trigger)
          state_nxt = (wr_type == `SWS_TYPE_S0) ? ST_WORK : ST_ENTER;
      end
      ST_ENTER: begin
        if (cpu_halted && seq_cnt_r == 8'h00)
          state_nxt = (cur_type_r == `SWS_TYPE_S5) ? ST_OFF : ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wake_event)
          state_nxt = ST_WAKE;
      end
      ST_WAKE: begin
        if (seq_cnt_r == 8'h00)
          state_nxt = ST_WORK;
      end
      ST_OFF: begin
        if (button_wake)
          state_nxt = ST_WAKE;
      end
      default: state_nxt = ST_WORK;
    endcase
    if (hold_done && state_r != ST_OFF && pb_level)
      state_nxt = ST_OFF;
  end

  // State, sequence timer and sleep type
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= ST_WORK;
      seq_cnt_r <= 8'h00;
      cur_type_r <= `SWS_TYPE_S0;
      sleep_type_select_r <= `SWS_TYPE_S0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        seq_cnt_r <= `SWS_SEQ_CYC;
      else if (seq_cnt_r != 8'h00)
        seq_cnt_r <= seq_cnt_r - 8'h01;
      // type may be reprogrammed while working
      if (wr_ctrl)
        sleep_type_select_r <= wr_type;
      if (trigger && state_r == ST_WORK)
        cur_type_r <= wr_type;
      else if (state_nxt == ST_OFF && state_r != ST_OFF)
        cur_type_r <= `SWS_TYPE_S5;
    end
  end

  // Status flags; hardware set wins over write-one-to-clear
  // Losing a clear is harmless, as software simply sees the flag again;
  // losing a set would hide a wake source. The one exception is the
  // override, which must leave the button flag clear even while the
  // press that caused it is still being seen.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      wake_flag_r <= 1'b0;
      alarm_wake_flag_r <= 1'b0;
      power_button_flag_r <= 1'b0;
      override_flag_r <= 1'b0;
    end else begin
      // wake flag set only from sleep; zero without S1
      if (state_r == ST_SLEEP && wake_event && S1_SUPPORT)
        wake_flag_r <= 1'b1;
      else if (trigger && state_r == ST_WORK)
        wake_flag_r <= 1'b0;
      else if (wr_stat && reg_wdata[`SWS_STAT_WAKE])
        wake_flag_r <= 1'b0;
      // flag from interrupt pin; sticky status
      if (alarm_event)
        alarm_wake_flag_r <= 1'b1;
      else if (wr_stat && reg_wdata[`SWS_STAT_ALARM])
        alarm_wake_flag_r <= 1'b0;
      if (hold_done && pb_level && state_r != ST_OFF)
        power_button_flag_r <= 1'b0;
      else if (pb_press)
        power_button_flag_r <= 1'b1;
      else if (wr_stat && reg_wdata[`SWS_STAT_PBTN])
        power_button_flag_r <= 1'b0;
      if (hold_done && pb_level && state_r != ST_OFF)
        override_flag_r <= 1'b1;
      else if (wr_stat && reg_wdata[`SWS_STAT_OVR])
        override_flag_r <= 1'b0;
    end
  end

  // Alarm enable and clock memory bytes
  // Bytes whose location parameter is zero ignore writes and read as zero,
  // so software sees an absent feature the same way on every access.
  // Day and month reset to an out-of-range value, giving a plain
  // time-of-day alarm until software programs them.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      alarm_en_r <= 1'b0;
      day_alarm_r <= 8'hff;
      mon_alarm_r <= 8'hff;
      century_r <= `SWS_CENTENARY_POINTER_RST;
      cur_day_r <= 8'h01;
      cur_mon_r <= 8'h01;
    end else if (reg_wr) begin
      // enable gates wake; day byte stored whole
      if (reg_addr == `SWS_OFF_ALEN)
        alarm_en_r <= reg_wdata[0];
      if (reg_addr == `SWS_OFF_DAY && day_present)
        day_alarm_r <= reg_wdata;
      if (reg_addr == `SWS_OFF_MON && mon_present)
        mon_alarm_r <= reg_wdata;
      // century byte; absent when location zero
      if (reg_addr == `SWS_OFF_CENTENARY_POINTER && CENTENARY_POINTER != 8'h00)
        century_r <= reg_wdata;
      if (reg_addr == `SWS_OFF_CUR)
        cur_day_r <= reg_wdata;
      if (reg_addr == `SWS_OFF_CFG)
        cur_mon_r <= reg_wdata;
    end
  end

  // Outputs and resume path
  // All outputs are registered; the resume pulses last one cycle, on the
  // edge where the wake sequence hands back to the working state.
  // The S5 code is shown while off, so observers can tell off from sleep.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      power_state <= `SWS_TYPE_S0;
      cpu_resume_in_driver <= 1'b0;
      cpu_reset_vector <= 1'b0;
      sleep_busy <= 1'b0;
    end else begin
      power_state <= (state_r == ST_SLEEP || state_r == ST_OFF) ? cur_type_r : `SWS_TYPE_S0;
      sleep_busy <= (state_r != ST_WORK);
      // S1 resumes in driver, deeper at reset vector
      cpu_resume_in_driver <= (state_r == ST_WAKE) && (state_nxt == ST_WORK) &&
                              (cur_type_r == `SWS_TYPE_S1);
      cpu_reset_vector <= (state_r == ST_WAKE) && (state_nxt == ST_WORK) &&
                          (cur_type_r != `SWS_TYPE_S1);
    end
  end

  // Read port; data valid in the cycle after the strobe
  // The data return to zero outside the read slot, so a bus that ORs
  // several slaves together needs no extra gating.
  // The trigger bit always reads zero; it is an action, not a state.
  always @(posedge sys_clk) begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `SWS_OFF_CTRL: reg_rdata <= {4'h0, sleep_type_select_r, 1'b0};
        `SWS_OFF_STAT: reg_rdata <= {4'h0, override_flag_r, power_button_flag_r,
                                     alarm_wake_flag_r, wake_flag_r};
        `SWS_OFF_ALEN: reg_rdata <= {6'h00, DEEP_ALARM_WAKE_SUPPORT, alarm_en_r};
        `SWS_OFF_DAY: reg_rdata <= day_present ? day_alarm_r : 8'h00;
        `SWS_OFF_MON: reg_rdata <= mon_present ? mon_alarm_r : 8'h00;
        `SWS_OFF_CENTENARY_POINTER: reg_rdata <= (CENTENARY_POINTER != 8'h00) ? century_r : 8'h00;
        `SWS_OFF_CUR: reg_rdata <= cur_day_r;
        `SWS_OFF_CFG: reg_rdata <= cur_mon_r;
        default: reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

//--- core/sws_map.vh
// Register offsets, field positions, reset values and timing for the sleep/wake sequencer
`ifndef SWS_MAP_VH
`define SWS_MAP_VH
`define SWS_ADDR_W 4
`define SWS_OFF_CTRL 4'h0
`define SWS_OFF_STAT 4'h1
`define SWS_OFF_ALEN 4'h2
`define SWS_OFF_DAY 4'h3
`define SWS_OFF_MON 4'h4
`define SWS_OFF_CENTENARY_POINTER 4'h5
`define SWS_OFF_CUR 4'h6
`define SWS_OFF_CFG 4'h7
`define SWS_CTRL_TRIG 0
`define SWS_CTRL_TYPE_LO 1
`define SWS_STAT_WAKE 0
`define SWS_STAT_ALARM 1
`define SWS_STAT_PBTN 2
`define SWS_STAT_OVR 3
`define SWS_TYPE_S0 3'h0
`define SWS_TYPE_S1 3'h1
`define SWS_TYPE_S2 3'h2
`define SWS_TYPE_S3 3'h3
`define SWS_TYPE_S4 3'h4
`define SWS_TYPE_S5 3'h5
`define SWS_CENTENARY_POINTER_RST 8'h19
`define SWS_CLK_HZ 25000000
`define SWS_HOLD_S 4
`define SWS_HOLD_CYC (`SWS_HOLD_S * `SWS_CLK_HZ + 1)
`define SWS_SEQ_CYC 8'h10
`endif

//--- verification/sws_sequencer_chk.sv
// Port-level assertions for the sleep/wake sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sws_map.vh"
module sws_sequencer_chk #(
  parameter HOLD_CYC = 50,
  parameter [0:0] DEEP_ALARM_WAKE_SUPPORT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic power_button_pin,
  input wire logic cpu_halted_pin,
  input wire logic [2:0] power_state,
  input wire logic cpu_resume_in_driver,
  input wire logic cpu_reset_vector,
  input wire logic sleep_busy
);
  logic [31:0] hold_cnt;
  logic [2:0] start_r;
  logic [2:0] last_sleep_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Press length, saturated so a stuck button cannot wrap the count
  always @(posedge sys_clk) begin
    if (!nrst || !power_button_pin) begin
      hold_cnt <= 0;
    end else if (hold_cnt < HOLD_CYC + 9) begin
      hold_cnt <= hold_cnt + 1;
    end
    if (power_button_pin && hold_cnt == 0) start_r <= power_state;
    if (!nrst) last_sleep_r <= 3'h0;
    else if (power_state != 3'h0) last_sleep_r <= power_state;
  end
  sequence s_long_hold;
    hold_cnt == HOLD_CYC + 8 && start_r == 3'h0;
  endsequence
  property p_override; s_long_hold |-> ##[0:24] power_state == `SWS_TYPE_S5; endproperty
  a_override: assert property (p_override) else $error("hold did not force off");
  property p_busy; power_state != 3'h0 |-> sleep_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy low while asleep");
  property p_range; power_state <= `SWS_TYPE_S5; endproperty
  a_range: assert property (p_range) else $error("illegal power state");
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_trig_rd; reg_rd && reg_addr == `SWS_OFF_CTRL |=> !reg_rdata[0]; endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("trigger bit read back");
  property p_deep_ro;
    reg_rd && reg_addr == `SWS_OFF_ALEN |=> reg_rdata[1] == DEEP_ALARM_WAKE_SUPPORT;
  endproperty
  a_deep_ro: assert property (p_deep_ro) else $error("deep wake flag wrong");
  property p_res_s1; cpu_resume_in_driver |-> last_sleep_r == `SWS_TYPE_S1 && !cpu_reset_vector;
  endproperty
  a_res_s1: assert property (p_res_s1) else $error("driver resume not from S1");
  property p_res_deep; cpu_reset_vector |-> last_sleep_r >= `SWS_TYPE_S2; endproperty
  a_res_deep: assert property (p_res_deep) else $error("reset vector from S1");
  property p_pulse; $rose(cpu_resume_in_driver) |=> !cpu_resume_in_driver; endproperty
  a_pulse: assert property (p_pulse) else $error("resume pulse too long");
  property p_halt;
    $past(power_state) == 3'h0 && power_state != 3'h0 && power_state != `SWS_TYPE_S5
      |-> $past(cpu_halted_pin, 3);
  endproperty
  a_halt: assert property (p_halt) else $error("slept with cpu running");
endmodule
`default_nettype wire

//--- verification/tb_sleep_wake_sequencer.sv
// Self-checking testbench for the sleep/wake sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sws_map.vh"
module tb_sleep_wake_sequencer;
  logic sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, power_button_pin = 0;
  logic alarm_irq_pin = 0, battery_low_pin = 0, cpu_halted_pin = 0, bcd_mode = 1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, n_res = 8'h00, n_rst = 8'h00;
  wire [7:0] reg_rdata;
  wire [2:0] power_state;
  wire cpu_resume_in_driver, cpu_reset_vector, sleep_busy;
  int failures = 0, tests_run = 0;
  always #20 sys_clk = ~sys_clk;
  // Short hold count keeps the override scenario brief
  sws_sequencer #(.HOLD_CYC(50)) uut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_button_pin(power_button_pin), .alarm_irq_pin(alarm_irq_pin),
    .battery_low_pin(battery_low_pin), .cpu_halted_pin(cpu_halted_pin), .bcd_mode(bcd_mode),
    .power_state(power_state), .cpu_resume_in_driver(cpu_resume_in_driver),
    .cpu_reset_vector(cpu_reset_vector), .sleep_busy(sleep_busy));
  // Count wake pulses of each kind
  always @(posedge sys_clk) begin
    if (cpu_resume_in_driver === 1'b1) n_res <= n_res + 8'h01;
    if (cpu_reset_vector === 1'b1) n_rst <= n_rst + 8'h01;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data are only valid in the slot right after the strobe edge
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic pin_pulse(input bit alarm, input int n);
    @(posedge sys_clk);
    if (alarm) alarm_irq_pin <= 1'b1; else power_button_pin <= 1'b1;
    cyc(n);
    alarm_irq_pin <= 1'b0; power_button_pin <= 1'b0;
    cyc(6);
  endtask
  task automatic wait_ps(input logic [2:0] s);
    repeat (300) begin
      if (power_state === s) break;
      @(posedge sys_clk);
      #1;
    end
    chk({5'h0, power_state}, {5'h0, s});
  endtask
  // Trigger, then confirm nothing happens until the cpu has stopped
  task automatic sleep(input logic [2:0] t);
    @(posedge sys_clk);
    cpu_halted_pin <= 1'b0;
    wr(`SWS_OFF_CTRL, {4'h0, t, 1'b1});
    cyc(30);
    #1 chk({5'h0, power_state}, 8'h00);
    @(posedge sys_clk);
    cpu_halted_pin <= 1'b1;
    wait_ps(t);
  endtask
  task automatic t_regs;
    rd(`SWS_OFF_CENTENARY_POINTER, 8'hff, 8'h19);
    rd(`SWS_OFF_DAY, 8'hff, 8'hff);
    rd(`SWS_OFF_ALEN, 8'h02, 8'h00);
    rd(`SWS_OFF_CTRL, 8'h01, 8'h00);
    rd(4'hf, 8'hff, 8'h00);
    wr(`SWS_OFF_CTRL, 8'h01);
    cyc(40);
    chk({7'h0, sleep_busy}, 8'h00);
  endtask
  task automatic t_alarm_wakes;
    wr(`SWS_OFF_ALEN, 8'h01);
    for (int t = 1; t <= 3; t++) begin
      n_res <= 8'h00; n_rst <= 8'h00;
      sleep(t[2:0]);
      pin_pulse(1, 4);
      wait_ps(3'h0);
      cyc(30);
      chk(n_res, {7'h0, t == 1});
      chk(n_rst, {7'h0, t != 1});
      rd(`SWS_OFF_STAT, 8'h03, 8'h03);
      wr(`SWS_OFF_STAT, 8'h0f);
    end
  endtask
  // Alarm blocked by low battery, then by lack of deep support
  task automatic t_blocked;
    battery_low_pin <= 1'b1;
    for (int t = 3; t <= 4; t++) begin
      sleep(t[2:0]);
      pin_pulse(1, 4);
      cyc(40);
      chk({5'h0, power_state}, t[7:0]);
      rd(`SWS_OFF_STAT, 8'h02, 8'h02);
      battery_low_pin <= 1'b0;
      pin_pulse(0, 8);
      wait_ps(3'h0);
      cyc(30);
      wr(`SWS_OFF_STAT, 8'h0f);
    end
  endtask
  task automatic t_day;
    wr(`SWS_OFF_DAY, 8'h05);
    wr(`SWS_OFF_CUR, 8'h06);
    pin_pulse(1, 4);
    rd(`SWS_OFF_STAT, 8'h02, 8'h00);
    wr(`SWS_OFF_DAY, 8'h3f);
    pin_pulse(1, 4);
    rd(`SWS_OFF_STAT, 8'h02, 8'h02);
    wr(`SWS_OFF_STAT, 8'h0f);
    bcd_mode <= 1'b0;
    wr(`SWS_OFF_DAY, 8'h1f);
    pin_pulse(1, 4);
    rd(`SWS_OFF_STAT, 8'h02, 8'h00);
    wr(`SWS_OFF_DAY, 8'h25);
    pin_pulse(1, 4);
    rd(`SWS_OFF_STAT, 8'h02, 8'h02);
    bcd_mode <= 1'b1;
    wr(`SWS_OFF_DAY, 8'hff);
    wr(`SWS_OFF_STAT, 8'h0f);
  endtask
  task automatic t_override;
    wr(`SWS_OFF_ALEN, 8'h00);
    pin_pulse(0, 90);
    wait_ps(`SWS_TYPE_S5);
    rd(`SWS_OFF_STAT, 8'h0c, 8'h08);
    wr(`SWS_OFF_STAT, 8'h0f);
    pin_pulse(0, 8);
    wait_ps(3'h0);
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(16);
    nrst <= 1'b1;
    t_regs;
    t_alarm_wakes;
    t_blocked;
    t_day;
    t_override;
    finish_test;
  end
  // Run needs under a thousand cycles; 50000 means a hang
  initial begin
    #2000000;
    failures++;
    finish_test;
  end
endmodule
bind sws_sequencer sws_sequencer_chk #(.HOLD_CYC(HOLD_CYC),
  .DEEP_ALARM_WAKE_SUPPORT(DEEP_ALARM_WAKE_SUPPORT)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .power_button_pin(power_button_pin), .cpu_halted_pin(cpu_halted_pin),
  .power_state(power_state), .cpu_resume_in_driver(cpu_resume_in_driver),
  .cpu_reset_vector(cpu_reset_vector), .sleep_busy(sleep_busy));
`default_nettype wire
